// *** sci_irq_model.sv ***
/*
 * Model of the processor-side interrupt controller watching the level line.
 * Assumes one core clock and the block's active-low reset.
 */
`timescale 1ns/1ps
module sci_irq_model (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic sysctl_irq,
    output int        irq_entries
);
    logic irq_seen;
    // A level left high is one entry only, so a missed clear shows as a count short.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_seen    <= 1'b0;
            irq_entries <= 0;
        end
        else
        begin
            irq_seen <= sysctl_irq;
            if (sysctl_irq && !irq_seen)
                irq_entries <= irq_entries + 1;
        end
    end
endmodule : sci_irq_model

// *** sci_pkg.sv ***
/*
 * Constants for the system-control event and configuration block.
 * Assumes an AXI4-Lite master with 32-bit data and one clock domain.
 */
package sci_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] RAW_STATUS_ADDR    = 8'h00;
    localparam logic [7:0] MASKED_STATUS_ADDR = 8'h04;
    localparam logic [7:0] ENABLE_ADDR        = 8'h08;
    localparam logic [7:0] CLEAR_ADDR         = 8'h0c;
    localparam logic [7:0] GPIO_SELECT_ADDR   = 8'h10;
    localparam logic [7:0] DEEP_SLEEP_LDO_ADDR = 8'h14;
    localparam logic [7:0] SLEEP_LDO_ADDR     = 8'h18;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         NUM_EVENTS   = 8;
    localparam int         NUM_PORTS    = 9;
    localparam int         LDO_WIDTH    = 3;
    localparam int         BROWNOUT_ZERO_BIT   = 0;
    localparam int         BROWNOUT_ONE_BIT    = 1;
    localparam int         GENERIC_BROWNOUT_BIT = 2;
    localparam int         ANALOG_SUPPLY_GOOD_BIT = 3;
    localparam int         MAIN_OSC_POWERED_BIT = 4;
    localparam int         USB_PLL_LOCKED_BIT  = 5;
    localparam int         MAIN_PLL_LOCKED_BIT = 6;
    localparam int         MAIN_OSC_FAILURE_BIT = 7;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [8:0] GPIO_SELECT_RESET = 9'h000;
    localparam logic [2:0] REGULATOR_SETTING_LOWEST  = 3'h0;
    localparam logic [2:0] REGULATOR_SETTING_HIGHEST = 3'h6;
    localparam logic [2:0] LDO_RESET    = 3'h6;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : sci_pkg

// *** sci_top.sv ***
/*
 * System-control event status, enable mask, interrupt, GPIO bus
 * selection and regulator fields behind an AXI4-Lite slave.
 * Assumes event inputs are asynchronous level pulses from detectors.
 */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sci_top #(
    parameter bit HOSTBUS_ONLY = 1'b0
) (
    input  wire logic                             core_clk,
    input  wire logic                             reset_n,
    input  wire logic [sci_pkg::NUM_EVENTS-1:0]   event_in,
    output logic                                  sysctl_irq,
    output logic      [sci_pkg::NUM_PORTS-1:0]    gpio_hostbus_sel,
    output logic      [sci_pkg::LDO_WIDTH-1:0]    deep_sleep_ldo,
    output logic      [sci_pkg::LDO_WIDTH-1:0]    sleep_ldo,
    input  wire logic [7:0]                       s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic      [1:0]                       s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [7:0]                       s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic      [31:0]                      s_axi_rdata,
    output logic      [1:0]                       s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready
);
    import sci_pkg::*;

    logic [NUM_EVENTS-1:0] sync_a;
    logic [NUM_EVENTS-1:0] sync_b;
    logic [NUM_EVENTS-1:0] sync_prev;
    logic [NUM_EVENTS-1:0] event_rise;
    logic [NUM_EVENTS-1:0] raw_status;
    logic [NUM_EVENTS-1:0] enable;
    logic [NUM_EVENTS-1:0] clear_pulse;
    logic [7:0]            aw_addr;
    logic                  aw_held;
    logic [31:0]           w_data;
    logic                  w_held;
    logic                  do_write;
    logic                  wr_hit;
    logic                  rd_hit;
    logic [31:0]           next_rdata;

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    // Detectors sit in other domains, so each event passes two flops.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_a    <= '0;
            sync_b    <= '0;
            sync_prev <= '0;
        end
        else
        begin
            sync_a    <= event_in;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    assign event_rise = sync_b & ~sync_prev;

    // ------------------------------------------------------------
    // Status, clear and enable
    // ------------------------------------------------------------
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    // The clear acts at the write handshake; any lag is in the master's buffering.
    assign clear_pulse = (do_write && aw_addr == CLEAR_ADDR)
                       ? w_data[NUM_EVENTS-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++)
        begin : g_status
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    raw_status[gi] <= 1'b0;
                else if (event_rise[gi])
                    raw_status[gi] <= 1'b1;
                else if (clear_pulse[gi])
                    raw_status[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            enable <= ENABLE_RESET;
        else if (do_write && aw_addr == ENABLE_ADDR)
            enable <= w_data[NUM_EVENTS-1:0];
    end

    // Registered so the output is glitch free; it lags status by one cycle.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            sysctl_irq <= 1'b0;
        else
            sysctl_irq <= |(raw_status & enable);
    end

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            gpio_hostbus_sel <= HOSTBUS_ONLY ? '1 : GPIO_SELECT_RESET;
        else if (!HOSTBUS_ONLY && do_write && aw_addr == GPIO_SELECT_ADDR)
            gpio_hostbus_sel <= w_data[NUM_PORTS-1:0];
    end

    // Illegal settings above the highest are refused so the field stays legal.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            deep_sleep_ldo <= LDO_RESET;
            sleep_ldo      <= LDO_RESET;
        end
        else if (do_write && w_data[LDO_WIDTH-1:0] <= REGULATOR_SETTING_HIGHEST)
        begin
            if (aw_addr == DEEP_SLEEP_LDO_ADDR)
                deep_sleep_ldo <= w_data[LDO_WIDTH-1:0];
            if (aw_addr == SLEEP_LDO_ADDR)
                sleep_ldo <= w_data[LDO_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign wr_hit = (aw_addr == ENABLE_ADDR) || (aw_addr == CLEAR_ADDR)
                 || (aw_addr == GPIO_SELECT_ADDR) || (aw_addr == DEEP_SLEEP_LDO_ADDR)
                 || (aw_addr == SLEEP_LDO_ADDR);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready)
            begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready)
            begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                s_axi_wready <= 1'b1;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        rd_hit     = 1'b1;
        unique case (s_axi_araddr)
            RAW_STATUS_ADDR:     next_rdata[NUM_EVENTS-1:0] = raw_status;
            MASKED_STATUS_ADDR:  next_rdata[NUM_EVENTS-1:0] = raw_status & enable;
            ENABLE_ADDR:         next_rdata[NUM_EVENTS-1:0] = enable;
            CLEAR_ADDR:          next_rdata = 32'h0000_0000;
            GPIO_SELECT_ADDR:    next_rdata[NUM_PORTS-1:0] = gpio_hostbus_sel;
            DEEP_SLEEP_LDO_ADDR: next_rdata[LDO_WIDTH-1:0] = deep_sleep_ldo;
            SLEEP_LDO_ADDR:      next_rdata[LDO_WIDTH-1:0] = sleep_ldo;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    irq_follows_mask_a: assert property ((|(raw_status & enable)) |=> sysctl_irq)
        else $error("interrupt not raised for enabled status");
    irq_gated_off_a: assert property (!(|(raw_status & enable)) |=> !sysctl_irq)
        else $error("interrupt raised with no enabled status");
    clear_drops_a: assert property ((clear_pulse[0] && !event_rise[0]) |=> !raw_status[0])
        else $error("clear did not drop status bit");
    clear_spares_a: assert property ((!clear_pulse[1] && raw_status[1]) |=> raw_status[1])
        else $error("unselected status bit lost");
    event_wins_a: assert property (event_rise[2] |=> raw_status[2])
        else $error("event lost against clear");
    ldo_legal_a: assert property (deep_sleep_ldo <= REGULATOR_SETTING_HIGHEST
                                  && sleep_ldo <= REGULATOR_SETTING_HIGHEST)
        else $error("regulator field outside legal range");
    hostbus_fixed_a: assert property (HOSTBUS_ONLY |-> (&gpio_hostbus_sel))
        else $error("port left on peripheral bus in host-only build");
    read_answer_a: assert property ((s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
                                    |=> s_axi_rvalid ##0 s_axi_arready)
        else $error("read not answered in one cycle");
    write_answer_a: assert property (do_write |=> s_axi_bvalid[*1] ##1 1'b1)
        else $error("write response missing");

    irq_seen_c: cover property (!sysctl_irq ##1 sysctl_irq ##[1:20] !sysctl_irq);
    clear_seen_c: cover property (raw_status[0] ##1 clear_pulse[0] ##1 !raw_status[0]);
    race_seen_c: cover property (event_rise[3] && clear_pulse[3]);
endmodule : sci_top

// *** test_sysctl_interrupt_and_config.sv ***
/*
 * Self-checking bench for the system-control event block.
 * Assumes sci_pkg, sci_top and sci_irq_model are compiled before it.
 */
`timescale 1ns/1ps
module test_sysctl_interrupt_and_config;
    import sci_pkg::*;
    logic        core_clk, reset_n, sysctl_irq;
    logic [7:0]  event_in, s_axi_awaddr, s_axi_araddr;
    logic [8:0]  gpio_hostbus_sel, hbo_sel;
    logic [2:0]  deep_sleep_ldo, sleep_ldo;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          err_total, checks, cycles, irq_entries, exp_entries;
    int          status, enable, gpio, ldo_ds, ldo_sl, ev, clr;

    sci_top i_dut (.*);
    // Host-bus-only build shares the bus inputs; its writes must never move its select.
    sci_top #(.HOSTBUS_ONLY(1'b1)) i_hbo (.*, .gpio_hostbus_sel(hbo_sel), .sysctl_irq(),
        .deep_sleep_ldo(), .sleep_ldo(), .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid());
    sci_irq_model i_cpu (.core_clk(core_clk), .reset_n(reset_n), .sysctl_irq(sysctl_irq),
        .irq_entries(irq_entries));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
        bit b_done = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_done)
        begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            b_done = (s_axi_bvalid === 1'b1);
            resp   = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] addr);
        bit r_done = 0;
        @(posedge core_clk);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_done)
        begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            r_done = (s_axi_rvalid === 1'b1);
            rd     = s_axi_rdata;
            resp   = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        axi_read(addr);
        check(rd, exp);
        check(32'(resp), 32'(RESP_OKAY));
    endtask : rd_chk

    task automatic fire(input logic [7:0] bits);
        @(posedge core_clk);
        event_in <= bits;
        repeat (3) @(posedge core_clk);
        event_in <= 8'h00;
        repeat (4) @(posedge core_clk);
    endtask : fire

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    initial
    begin
        {reset_n, event_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        seed        = 32'd76;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(ENABLE_ADDR, 32'(ENABLE_RESET));
        rd_chk(RAW_STATUS_ADDR, 32'h0);
        ldo_ds = LDO_RESET;
        ldo_sl = LDO_RESET;
        rd_chk(DEEP_SLEEP_LDO_ADDR, ldo_ds);
        rd_chk(SLEEP_LDO_ADDR, ldo_sl);
        $display("Reset values test done");
        repeat (4)
        begin
            gpio = xorshift() & 'h1ff;
            axi_write(GPIO_SELECT_ADDR, gpio);
            rd_chk(GPIO_SELECT_ADDR, gpio);
            check(32'(gpio_hostbus_sel), gpio);
            check(32'(hbo_sel), 32'h1ff);
        end
        axi_write(8'h1c, 32'hffffffff);
        check(32'(resp), 32'(RESP_SLVERR));
        axi_read(8'h1c);
        check(32'(resp), 32'(RESP_SLVERR));
        $display("Port select test done");
        for (int v = 0; v < 8; v++)
        begin
            axi_write(DEEP_SLEEP_LDO_ADDR, v);
            axi_write(SLEEP_LDO_ADDR, (v + 3) % 8);
            ldo_ds = (v <= 6) ? v : ldo_ds;
            ldo_sl = (((v + 3) % 8) <= 6) ? (v + 3) % 8 : ldo_sl;
            rd_chk(DEEP_SLEEP_LDO_ADDR, ldo_ds);
            rd_chk(SLEEP_LDO_ADDR, ldo_sl);
            check(32'(deep_sleep_ldo), ldo_ds);
            check(32'(sleep_ldo), ldo_sl);
        end
        $display("Regulator test done");
        for (int i = 0; i < 6; i++)
        begin
            ev     = xorshift() & 'hff;
            enable = (i == 0) ? 0 : xorshift() & 'hff;
            axi_write(ENABLE_ADDR, enable);
            fire(ev[7:0]);
            status = status | ev;
            rd_chk(RAW_STATUS_ADDR, status);
            rd_chk(MASKED_STATUS_ADDR, status & enable);
            check(32'(sysctl_irq), 32'((status & enable) != 0));
            exp_entries += ((status & enable) != 0);
            clr = xorshift() & 'hff;
            axi_write(CLEAR_ADDR, clr);
            status = status & ~clr;
            rd_chk(RAW_STATUS_ADDR, status);
            check(32'(sysctl_irq), 32'((status & enable) != 0));
            axi_write(CLEAR_ADDR, 32'hff);
            status = 0;
        end
        // The event is timed so its synced edge meets the clear's handshake edge.
        axi_write(ENABLE_ADDR, 32'h0);
        @(posedge core_clk);
        event_in <= 8'h08;
        axi_write(CLEAR_ADDR, 32'hff);
        event_in <= 8'h00;
        rd_chk(RAW_STATUS_ADDR, 32'h8);
        axi_write(CLEAR_ADDR, 32'hff);
        rd_chk(RAW_STATUS_ADDR, 32'h0);
        check(irq_entries, exp_entries);
        $display("Event test done");
        final_report();
    end
endmodule : test_sysctl_interrupt_and_config
